/* core/dsfr_des_end.sv */
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Functional notes
// - Slow bit 0, codes 1-4, /2168 modulation.
// - Slow bit 0, codes 5 /21300, 6-7 /1300.
// - Slow bit 1, codes 1-4, /625 modulation.
// - Slow bit 1, codes 5-7, /385 modulation.
// - Carry 24 colour bits with pixel clock.
// - Carry and reproduce vertical, horizontal, active.
// - Pixel clock stays within 5 to 50 MHz.
// - Narrow colour frees bits for general purpose.
// - Slow range bit selects code interpretation.
// =============================================================
module dsfr_des_end
   import dsfr_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   dsfr_link_if.dev         link,
   input  wire logic        narrow_color,
   output logic [23:0]      pix_color,
   output logic             vertical_sync,
   output logic             horizontal_sync,
   output logic             pixel_active,
   output logic             pix_valid,
   output logic [5:0]       gp_out,
   output logic [2:0]       input_boost_gain,
   output logic             input_boost_on,
   output logic [2:0]       spread_select_field,
   output logic             slow_pixel_range,
   output logic             spread_on,
   output logic [7:0]       spread_dev_hundredths,
   output logic             spread_mod_tick
);

   // =============================================================
   // Registers written through the link's control words.
   // =============================================================
   logic [7:0] features_r;
   logic [7:0] mode_r;
   wire  [7:0] w_idx = link.word[15:8];
   wire  [7:0] w_dat = link.word[7:0];
   wire        w_hit = link.pclk_en && link.ctl_write;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         features_r <= DSFR_FEATURES_RST;
         mode_r     <= DSFR_MODE_RST;
      end
      else if (w_hit)
      begin
         // gain field and enable, reserved bit kept zero.
         if (w_idx == DSFR_IDX_FEATURES_TWO)
            features_r <= w_dat & DSFR_FEATURES_WMASK;
         if (w_idx == DSFR_IDX_MODE)
            mode_r <= w_dat;
      end
   assign link.status = features_r;

   assign input_boost_gain    = features_r[DSFR_GAIN_MSB:DSFR_GAIN_LSB];
   assign input_boost_on      = features_r[DSFR_BOOST_BIT];
   assign spread_select_field = features_r[DSFR_SPREAD_MSB:0];
   // slow range bit from the mode register.
   assign slow_pixel_range    = mode_r[DSFR_SLOW_BIT];

   // =============================================================
   // Spread clock: deviation and modulation divider per code.
   // =============================================================
   logic [14:0] mod_div;
   always_comb
   begin
      mod_div = 15'(DSFR_DIV_FAST_LOW);
      if (slow_pixel_range)
         mod_div = spread_select_field[2] && (spread_select_field[1:0] != 2'b00) ?
                   15'(DSFR_DIV_SLOW_HIGH) : 15'(DSFR_DIV_SLOW_LOW);
      else
         case (spread_select_field)
            // code 5 uses the printed long divider, 6 and 7 the short.
            3'h5:    mod_div = 15'(DSFR_DIV_FAST_101);
            3'h6,
            3'h7:    mod_div = 15'(DSFR_DIV_FAST_HIGH);
            // codes 1-4 at the common divider.
            default: mod_div = 15'(DSFR_DIV_FAST_LOW);
         endcase
   end
   assign spread_on             = (spread_select_field != 3'h0);
   assign spread_dev_hundredths = slow_pixel_range ? DSFR_DEV_SLOW[spread_select_field]
                                                   : DSFR_DEV_FAST[spread_select_field];

   // Modulation tick counts output pixel strobes; idle when off.
   logic [14:0] mod_cnt_r;
   wire         mod_end = (mod_cnt_r >= mod_div - 15'h0001);
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         mod_cnt_r       <= 15'h0000;
         spread_mod_tick <= 1'b0;
      end
      else
      begin
         spread_mod_tick <= spread_on && link.pclk_en && mod_end;
         if (!spread_on)
            mod_cnt_r <= 15'h0000;
         else if (link.pclk_en)
            mod_cnt_r <= mod_end ? 15'h0000 : mod_cnt_r + 15'h0001;
      end

   // =============================================================
   // Pixel output: colour, controls, general purpose bits.
   // =============================================================
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         pix_color       <= 24'h000000;
         vertical_sync   <= 1'b0;
         horizontal_sync <= 1'b0;
         pixel_active    <= 1'b0;
         pix_valid       <= 1'b0;
         gp_out          <= 6'h00;
      end
      else
      begin
         pix_valid <= link.pclk_en && !link.ctl_write;
         if (link.pclk_en && !link.ctl_write)
         begin
            pix_color       <= link.word[23:0];
            vertical_sync   <= link.word[24];
            horizontal_sync <= link.word[25];
            pixel_active    <= link.word[26];
            // general purpose bits in narrow colour use.
            gp_out          <= narrow_color ? {link.word[17:16], link.word[9:8], link.word[1:0]} : 6'h00;
         end
      end
endmodule : dsfr_des_end
`default_nettype wire

/* core/dsfr_ser_end.sv */
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Host end: pixel pacing, payload packing and control writes.
// =============================================================
module dsfr_ser_end
   import dsfr_pkg::*;
#(
   parameter int PCLK_DIV = DSFR_PCLK_DIV_MIN
)(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [23:0]       pix_color,
   input  wire logic              vertical_sync,
   input  wire logic              horizontal_sync,
   input  wire logic              pixel_active,
   input  wire logic              narrow_color,
   input  wire logic [5:0]        gp_in,
   output logic                   pix_take,
   dsfr_link_if.host              link
);

   // =============================================================
   // Pixel strobe divider, set to a rate between 5 and 50 MHz.
   // =============================================================
   logic [5:0] div_r;
   wire        div_end = (div_r == 6'(PCLK_DIV - 1));
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) div_r <= 6'h00;
      else          div_r <= div_end ? 6'h00 : div_r + 6'h01;

   // =============================================================
   // AHB-Lite slave: writes are queued for the next pixel slot.
   // =============================================================
   logic        wr_ph_r;
   logic [7:0]  wr_idx_r;
   logic        pend_r;
   logic [15:0] pend_word_r;
   wire         a_phase = hsel && hready && htrans[1];
   wire [7:0]   a_idx   = haddr[9:2];
   wire         busy    = pend_r || wr_ph_r;
   assign hreadyout = !(wr_ph_r && pend_r);  // Stall a second write until the first goes out.
   assign hresp     = 1'b0;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_ph_r  <= 1'b0;
         wr_idx_r <= 8'h00;
         hrdata   <= 32'h00000000;
      end
      else if (hreadyout)
      begin
         wr_ph_r  <= a_phase && hwrite;
         wr_idx_r <= a_idx;
         hrdata   <= (a_phase && !hwrite && a_idx == DSFR_IDX_STATUS) ? {24'h000000, link.status} : 32'h00000000;
      end

   // Pending write leaves on the next pixel strobe.
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         pend_r      <= 1'b0;
         pend_word_r <= 16'h0000;
      end
      else if (wr_ph_r && !pend_r)
      begin
         pend_r      <= 1'b1;
         pend_word_r <= {wr_idx_r, hwdata[7:0]};
      end
      else if (div_end)
         pend_r <= 1'b0;

   // =============================================================
   // Link word: colour, three controls, general purpose bits.
   // =============================================================
   logic [23:0] col_sel;
   always_comb
   begin
      col_sel = pix_color;
      // in 18-bit use the low two bits per colour carry gp bits.
      if (narrow_color)
      begin
         col_sel[1:0]   = gp_in[1:0];
         col_sel[9:8]   = gp_in[3:2];
         col_sel[17:16] = gp_in[5:4];
      end
   end
   assign pix_take = div_end && !pend_r;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         link.pclk_en   <= 1'b0;
         link.word      <= 32'h00000000;
         link.ctl_write <= 1'b0;
      end
      else
      begin
         // strobe paced by the divider within 5 to 50 MHz.
         link.pclk_en   <= div_end;
         link.ctl_write <= div_end && pend_r;
         if (div_end && pend_r)
            link.word <= {16'h0000, pend_word_r};
         else if (div_end)
            link.word <= {5'h00, pixel_active, horizontal_sync, vertical_sync, col_sel};
      end
   wire unused_ok = &{1'b0, hsize, busy};
endmodule : dsfr_ser_end
`default_nettype wire

/* include/dsfr_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Serial link between the host end and the display end.
// =============================================================
interface dsfr_link_if;
   logic        pclk_en;     // One-cycle pixel strobe.
   logic [31:0] word;        // Colour, controls, or a register write.
   logic        ctl_write;   // Word carries a control-bus register write.
   logic [7:0]  status;      // Back channel: register readback.

   modport host (output pclk_en, output word, output ctl_write, input status);
   modport dev  (input pclk_en, input word, input ctl_write, output status);
endinterface : dsfr_link_if
`default_nettype wire

/* include/dsfr_pkg.sv */
// =============================================================
// Shared constants for the pixel link and its feature register.
// =============================================================
package dsfr_pkg;

   // =============================================================
   // Register map, reached over AHB-Lite at the serializer end.
   // =============================================================
   localparam logic [7:0]  DSFR_IDX_FEATURES_TWO = 8'h03;                // Printed register index.
   localparam logic [7:0]  DSFR_IDX_MODE         = 8'h00;                // Holds the slow range bit.
   localparam logic [7:0]  DSFR_IDX_STATUS       = 8'h04;                // Deserializer status mirror.
   localparam logic [31:0] DSFR_ADDR_FEATURES    = 32'h0000000c;         // Four times the index.
   localparam logic [31:0] DSFR_ADDR_MODE        = 32'h00000000;
   localparam logic [31:0] DSFR_ADDR_STATUS      = 32'h00000010;
   localparam logic [7:0]  DSFR_FEATURES_RST     = 8'h00;
   localparam logic [7:0]  DSFR_MODE_RST         = 8'h00;
   localparam logic [7:0]  DSFR_FEATURES_WMASK   = 8'hf7;                // Bit 3 is reserved.
   localparam int          DSFR_GAIN_MSB         = 7;
   localparam int          DSFR_GAIN_LSB         = 5;
   localparam int          DSFR_BOOST_BIT        = 4;
   localparam int          DSFR_SPREAD_MSB       = 2;
   localparam int          DSFR_SLOW_BIT         = 7;

   // =============================================================
   // Spread clock modulation dividers, in output clock periods.
   // =============================================================
   localparam int DSFR_DIV_FAST_LOW  = 2168;
   localparam int DSFR_DIV_FAST_101  = 21300;
   localparam int DSFR_DIV_FAST_HIGH = 1300;
   localparam int DSFR_DIV_SLOW_LOW  = 625;
   localparam int DSFR_DIV_SLOW_HIGH = 385;

   // Deviation in hundredths of a percent, indexed by code.
   localparam logic [7:0] DSFR_DEV_FAST [8] = '{8'd0, 8'd90, 8'd120, 8'd190, 8'd230, 8'd70, 8'd130, 8'd157};
   localparam logic [7:0] DSFR_DEV_SLOW [8] = '{8'd0, 8'd70, 8'd130, 8'd180, 8'd220, 8'd70, 8'd120, 8'd170};

   // =============================================================
   // Link payload and framing.
   // =============================================================
   localparam int          DSFR_COLOR_W      = 24;
   localparam int          DSFR_WORD_W       = 32;                        // Colour, three controls, five spare bits; the write flag travels on ctl_write.
   localparam int          DSFR_GP_MAX       = 6;
   localparam int          DSFR_PCLK_MIN_MHZ = 5;
   localparam int          DSFR_PCLK_MAX_MHZ = 50;
   localparam int          DSFR_HCLK_MHZ     = 200;
   localparam int          DSFR_PCLK_DIV_MIN = DSFR_HCLK_MHZ / DSFR_PCLK_MAX_MHZ;  // 4 cycles at 50 MHz.
   localparam int          DSFR_PCLK_DIV_MAX = DSFR_HCLK_MHZ / DSFR_PCLK_MIN_MHZ;  // 40 cycles at 5 MHz.

   typedef enum logic [1:0] {DSFR_BUS_IDLE, DSFR_BUS_DATA} dsfr_bus_e;

endpackage : dsfr_pkg

/* testbench/deserializer_features_reg_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Bench for the pixel link and its feature register.
// =============================================================
module deserializer_features_reg_tb
   import dsfr_pkg::*;
;
   localparam int DIV = 8;                 // 25 MHz pixel rate.
   logic        hclk, hresetn, hwrite, hreadyout, hresp, vs, hs, act, narrow;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [23:0] pix, d_pix;
   logic        d_vs, d_hs, d_act, pix_valid, boost, slow, son, tick;
   logic [5:0]  gp_in, gp_out;
   logic [2:0]  gain, sel;
   logic [7:0]  dev;
   logic [7:0]  dev_f [8] = '{8'd0, 8'd90, 8'd120, 8'd190, 8'd230, 8'd70, 8'd130, 8'd157};
   logic [7:0]  dev_s [8] = '{8'd0, 8'd70, 8'd130, 8'd180, 8'd220, 8'd70, 8'd120, 8'd170};
   int          n_fail, compares, cyc;

   dsfr_link_if link();
   dsfr_ser_end #(.PCLK_DIV(DIV)) u_dsfr_ser_end(.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
      .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pix_color(pix),
      .vertical_sync(vs), .horizontal_sync(hs), .pixel_active(act), .narrow_color(narrow), .gp_in,
      .pix_take(), .link(link));
   dsfr_des_end u_dsfr_des_end(.hclk, .hresetn, .link(link), .narrow_color(narrow), .pix_color(d_pix),
      .vertical_sync(d_vs), .horizontal_sync(d_hs), .pixel_active(d_act), .pix_valid, .gp_out,
      .input_boost_gain(gain), .input_boost_on(boost), .spread_select_field(sel), .slow_pixel_range(slow),
      .spread_on(son), .spread_dev_hundredths(dev), .spread_mod_tick(tick));
   dsfr_monitor #(.PCLK_DIV(DIV)) u_dsfr_monitor(.hclk, .hresetn, .pclk_en(link.pclk_en),
      .word(link.word), .ctl_write(link.ctl_write), .status(link.status));

   // Free-running clock; the cycle ceiling cuts a hang short.
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_fail++;
         print_verdict;
      end
   end

   // =============================================================
   // Shared tasks.
   // =============================================================
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One single transfer; entered and left at a rising edge.
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   // =============================================================
   // Scenarios.
   // =============================================================
   task t_reset;
      ahb(1'b0, DSFR_ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b0, 32'h00000014, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      $display("t_reset done");
   endtask : t_reset

   // Every code under both ranges; reserved bit 3 is written as one.
   task t_spread;
      for (int s = 0; s < 2; s++)
         for (int c = 0; c < 8; c++)
         begin
            ahb(1'b1, DSFR_ADDR_MODE, {24'h0, s[0], 7'h0});
            ahb(1'b1, DSFR_ADDR_FEATURES, {24'h0, c[2:0], c[0], 1'b1, c[2:0]});
            repeat (4 * DIV) @(posedge hclk);
            chk({gain, boost, sel, slow, son}, {c[2:0], c[0], c[2:0], s[0], c != 0});
            chk(dev, s ? dev_s[c] : dev_f[c]);
            ahb(1'b0, DSFR_ADDR_STATUS, 32'h0);
            chk(rd, {24'h0, c[2:0], c[0], 1'b0, c[2:0]});
         end
      $display("t_spread done");
   endtask : t_spread

   // Pixel strobes between two modulation ticks.
   task t_tick(input logic s, input logic [2:0] c, input logic [31:0] div);
      int n, k;
      ahb(1'b1, DSFR_ADDR_MODE, {24'h0, s, 7'h0});
      ahb(1'b1, DSFR_ADDR_FEATURES, {29'h0, c});
      n = 0;
      k = 0;
      while (k < 2)
      begin
         @(posedge hclk);
         if (k == 1)
            n += link.pclk_en;
         if (tick === 1'b1)
            k++;
      end
      chk(n, div);
      $display("t_tick done");
   endtask : t_tick

   task t_pixel(input logic [23:0] c, input logic [2:0] ctl, input logic nc, input logic [5:0] gp);
      int m;
      {pix, vs, hs, act, narrow, gp_in} <= {c, ctl, nc, gp};
      repeat (3 * DIV) @(posedge hclk);
      // With no write pending, every strobe gives exactly one valid pulse.
      m = 0;
      repeat (2 * DIV)
      begin
         @(posedge hclk);
         m += (pix_valid === 1'b1);
      end
      chk(m, 32'd2);
      if (nc)
         chk(gp_out, gp);
      else
         chk({d_pix, d_vs, d_hs, d_act}, {c, ctl});
      $display("t_pixel done");
   endtask : t_pixel

   task print_verdict;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // Main sequence after 20 cycles of reset.
   initial
   begin
      {hresetn, hwrite, htrans, haddr, hwdata, pix, vs, hs, act, narrow, gp_in} = '0;
      n_fail = 0;
      compares = 0;
      cyc = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_spread;
      t_tick(1'b1, 3'h1, 32'd625);
      t_tick(1'b1, 3'h5, 32'd385);
      t_tick(1'b0, 3'h6, 32'd1300);
      t_tick(1'b0, 3'h2, 32'd2168);
      t_pixel(24'ha5c3e1, 3'b101, 1'b0, 6'h00);
      t_pixel(24'h5a3c1e, 3'b010, 1'b0, 6'h00);
      t_pixel(24'h000000, 3'b000, 1'b1, 6'h2d);
      print_verdict;
   end
endmodule : deserializer_features_reg_tb
`default_nettype wire

/* testbench/dsfr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// =============================================================
// Link checker between the two ends.
// =============================================================
module dsfr_monitor
   import dsfr_pkg::*;
#(
   parameter int PCLK_DIV = DSFR_PCLK_DIV_MIN
)(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        pclk_en,
   input wire logic [31:0] word,
   input wire logic        ctl_write,
   input wire logic [7:0]  status
);
   localparam int FIRST_MAX = PCLK_DIV + 2;
   logic [7:0] gap_r;
   logic       seen_r;
   // A features write is a control slot that names index three.
   wire        feat_wr = pclk_en && ctl_write && (word[15:8] == DSFR_IDX_FEATURES_TWO);

   // Cycles since the last strobe; the first strobe after reset has no reference.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gap_r  <= 8'h00;
         seen_r <= 1'b0;
      end
      else
      begin
         gap_r  <= pclk_en ? 8'h00 : gap_r + 8'h01;
         seen_r <= seen_r | pclk_en;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // =============================================================
   // Properties.
   // =============================================================
   property p_strobe_period; pclk_en && seen_r |-> gap_r == PCLK_DIV - 1; endproperty
   property p_strobe_late; seen_r |-> gap_r < PCLK_DIV; endproperty
   property p_strobe_single; pclk_en |=> !pclk_en; endproperty
   property p_first_strobe; $rose(hresetn) |-> ##[0:FIRST_MAX] pclk_en; endproperty
   property p_ctl_on_strobe; ctl_write |-> pclk_en; endproperty
   property p_status_hold; !$past(feat_wr) |-> $stable(status); endproperty
   property p_status_value; feat_wr |=> status == ($past(word[7:0]) & DSFR_FEATURES_WMASK); endproperty
   property p_status_reset; $rose(hresetn) |-> status == 8'h00; endproperty

   a_strobe_period: assert property (p_strobe_period)
      else $error("pixel strobe spacing wrong");
   a_strobe_late: assert property (p_strobe_late)
      else $error("pixel strobe missing");
   a_strobe_single: assert property (p_strobe_single)
      else $error("pixel strobe longer than one cycle");
   a_first_strobe: assert property (p_first_strobe)
      else $error("no pixel strobe after reset");
   a_ctl_on_strobe: assert property (p_ctl_on_strobe)
      else $error("control flag outside a strobe");
   a_status_hold: assert property (p_status_hold)
      else $error("status changed without a write");
   a_status_value: assert property (p_status_value)
      else $error("status does not match written byte");
   a_status_reset: assert property (p_status_reset)
      else $error("status not zero after reset");

   // Main scenarios reached.
   c_feat_write: cover property (feat_wr);
   c_sync_pixel: cover property (pclk_en && !ctl_write && word[24]);
   c_boost_set: cover property (status[4]);
endmodule : dsfr_monitor
`default_nettype wire
